// file: verilog/ias_add_unit.sv
// integer add unit: register and byte-constant sums, scalar or partitioned
// assumes the decoder issues at most one operation per cycle and schedules the
// two writeback ports; the register file resolves writes to register zero
`timescale 1ns/1ns
// Contract
// RL1: register form adds fields 17-12, 11-6 into 5-0
// RL2: bits 23-22 choose size; scalar uses low part
// RL3: bit 21 splits word into carry-free chunks
// RL4: bit 19 clamps overflow to size maximum
// RL5: bit 18 writes 0x00/0x01 carry to dest+1
// RL6: no option set: overflow discarded, wrap-around
// RL7: saturation and carry act per chunk
// RL8: byte constant bits 19-12, zero-extended
// RL9: constant form has only size, SIMD, reserved
// RL10: constant added to every chunk when partitioned
// RL11: byte ops one cycle, wider two cycles
// RL12: new operation accepted every cycle
// RL13: feeding code keeps reserved bits zero
// RL14: size 00/01/10/11 = 1/2/4/8 bytes, narrow maps 11
// RL15: carry to register 63 is dropped; the code drops the carry of dest 63, bound for register 0
// RL16: feeding code never sets saturation and carry
// RL17: opcode values are implementation parameters
// RL18: saturation plus carry flagged illegal, not executed
module ias_add_unit
  import ias_pkg::*;
#(
  parameter logic [7:0] REG_SUM_OPC = REG_SUM_OPC_DEF,  // RL17
  parameter logic [7:0] IMM_SUM_OPC = IMM_SUM_OPC_DEF
)(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  ias_issue_t       issue,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output ias_wb_t          shortWb,
  output ias_wb_t          longWb,
  output logic             illegalOp
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [7:0]  opc;
  logic        isReg;
  logic        isImm;
  logic [1:0]  sizeCode;
  logic        simd;
  logic        satSel;
  logic        carrySel;
  logic        bad;
  logic        go;
  logic [7:0]  imm;
  logic [5:0]  dest;
  logic [2:0]  mask;
  logic [7:0]  active;
  logic [63:0] addend;
  logic [63:0] opB;
  // state is declared up here because the size decode already reads the narrow bit
  ias_state_t  cur;
  ias_state_t  nxt;

  assign opc      = issue.instr[OPC_HI:OPC_LO];
  assign isReg    = (opc == REG_SUM_OPC);
  assign isImm    = (opc == IMM_SUM_OPC);
  assign simd     = issue.instr[SIMD_BIT];                   // RL3
  assign satSel   = isReg & issue.instr[SAT_BIT];            // RL4 RL9
  assign carrySel = isReg & issue.instr[CARRY_BIT];          // RL5 RL9
  assign bad      = issue.valid & satSel & carrySel;         // RL18
  assign go       = issue.valid & (isReg | isImm) & ~bad;    // RL12
  assign imm      = issue.instr[IMM_HI:IMM_LO];              // RL8
  assign dest     = issue.instr[DST_HI:DST_LO];              // RL1
  assign opB      = issue.srcSecond;                         // RL1

  // size code; with the narrow control bit set, the largest code means four bytes
  always_comb begin
    sizeCode = issue.instr[SIZE_HI:SIZE_LO];
    if (cur.narrow && sizeCode == SZ_OCTA) begin
      sizeCode = SZ_QUAD;                                    // RL14
    end
    case (sizeCode)                                          // RL14
      SZ_BYTE:   mask = MASK_BYTE;
      SZ_DOUBLE: mask = MASK_DOUBLE;
      SZ_QUAD:   mask = MASK_QUAD;
      default:   mask = MASK_OCTA;
    endcase
  end

  // active bytes and second operand
  always_comb begin
    for (int i = 0; i < NBYTE; i++) begin
      // scalar: only the low chunk takes part; partitioned: all bytes
      active[i] = simd | ((3'(i) & ~mask) == 3'h0);          // RL2 RL3
      if (isImm) begin
        // zero-extended constant in the low byte of every active chunk
        addend[8*i +: 8] = (active[i] && (3'(i) & mask) == 3'h0) ? imm : 8'h00;  // RL8 RL10
      end else begin
        addend[8*i +: 8] = issue.srcFirst[8*i +: 8];         // RL1
      end
    end
  end

  // ----------------------------------------------------------------
  // byte slices
  // ----------------------------------------------------------------
  logic [63:0] sl0;
  logic [63:0] sl1;
  logic [7:0]  slc0;
  logic [7:0]  slc1;

  for (genvar g = 0; g < NBYTE; g++) begin : g_slice
    ias_byte_slice u_slice (
      .a     (opB[8*g +: 8]),
      .b     (addend[8*g +: 8]),
      .sum0  (sl0[8*g +: 8]),
      .sum1  (sl1[8*g +: 8]),
      .cout0 (slc0[g]),
      .cout1 (slc1[g])
    );
  end

  // ----------------------------------------------------------------
  // carry chain, clamp and neighbour word
  // ----------------------------------------------------------------
  // chain is cut at every chunk start, so chunks never see each other
  function automatic ias_wb_t finish(input logic [63:0] s0,
                                     input logic [63:0] s1,
                                     input logic [63:0] passB,
                                     input logic [7:0]  c0,
                                     input logic [7:0]  c1,
                                     input logic [7:0]  act,
                                     input logic [2:0]  msk,
                                     input logic        sat,
                                     input logic        carryEn,
                                     input logic [5:0]  dst);
    ias_wb_t    w;
    logic [7:0] co;
    logic [7:0] ci;
    logic [7:0] top;
    logic       prev;
    logic       nextTop;
    logic       start;
    w       = '0;
    co      = '0;
    ci      = '0;
    top     = '0;
    prev    = 1'b0;
    nextTop = 1'b0;
    for (int i = 0; i < NBYTE; i++) begin
      start = ((3'(i) & msk) == 3'h0);
      ci[i] = start ? 1'b0 : prev;                           // RL3
      co[i] = ci[i] ? c1[i] : c0[i];
      prev  = co[i];
    end
    // overflow of a chunk is the carry out of its top byte
    for (int i = NBYTE - 1; i >= 0; i--) begin
      top[i]  = ((3'(i) & msk) == msk) ? co[i] : nextTop;
      nextTop = top[i];
    end
    for (int i = 0; i < NBYTE; i++) begin
      start = ((3'(i) & msk) == 3'h0);
      if (!act[i]) begin
        w.data[8*i +: 8] = passB[8*i +: 8];                  // RL2
      end else if (sat && top[i]) begin
        w.data[8*i +: 8] = 8'hff;                            // RL4 RL7
      end else begin
        w.data[8*i +: 8] = ci[i] ? s1[8*i +: 8] : s0[8*i +: 8];  // RL6
      end
      if (act[i] && start && carryEn) begin
        w.carryData[8*i +: 8] = {7'h00, top[i]};             // RL5 RL7
      end
    end
    w.valid      = 1'b1;
    w.dest       = dst;
    w.carryValid = carryEn && (dst != REG_LAST);             // RL15
    w.carryDest  = 6'(dst + 6'h01);                          // RL5
    return w;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic       busHit;
  logic       byteOp;

  assign busHit = wb_cyc_i & wb_stb_i & ~cur.ack;
  assign byteOp = (mask == MASK_BYTE);

  // next state: pipeline, op counter and wishbone slave
  always_comb begin
    nxt         = cur;
    nxt.illegal = bad;                                       // RL18
    nxt.opCount = go ? 32'(cur.opCount + 32'h1) : cur.opCount;
    // byte ops leave after one register, the rest after two
    nxt.shortWb = '0;
    if (go && byteOp) begin
      nxt.shortWb = finish(sl0, sl1, opB, slc0, slc1, active, mask,
                           satSel, carrySel, dest);          // RL11
    end
    nxt.stage.valid   = go & ~byteOp;                        // RL11 RL12
    nxt.stage.dest    = dest;
    nxt.stage.sat     = satSel;
    nxt.stage.carryEn = carrySel;
    nxt.stage.mask    = mask;
    nxt.stage.active  = active;
    nxt.stage.passB   = opB;
    nxt.stage.s0      = sl0;
    nxt.stage.s1      = sl1;
    nxt.stage.c0      = slc0;
    nxt.stage.c1      = slc1;
    nxt.longWb = '0;
    if (cur.stage.valid) begin
      nxt.longWb = finish(cur.stage.s0, cur.stage.s1, cur.stage.passB, cur.stage.c0,
                          cur.stage.c1, cur.stage.active, cur.stage.mask,
                          cur.stage.sat, cur.stage.carryEn, cur.stage.dest);  // RL11
    end
    // bus: ack one cycle after the strobe, dropped the cycle after
    nxt.ack   = busHit;
    nxt.rdata = 32'h0;
    if (busHit && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == ADR_CTRL) begin
        nxt.narrow = wb_dat_i[CTRL_NARROW];
      end
      if (wb_adr_i == ADR_STATUS && wb_dat_i[STAT_ILLEGAL]) begin
        nxt.illegalSticky = 1'b0;
      end
    end
    if (busHit && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL:   nxt.rdata = {31'h0, cur.narrow};
        ADR_STATUS: nxt.rdata = {31'h0, cur.illegalSticky};
        ADR_COUNT:  nxt.rdata = cur.opCount;
        default:    nxt.rdata = 32'h0;                       // unmapped reads zero
      endcase
    end
    // a new illegal op beats a clear in the same cycle
    if (bad) begin
      nxt.illegalSticky = 1'b1;                              // RL18
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur        <= '0;
      cur.narrow <= CTRL_NARROW_RST;
    end else begin
      cur <= nxt;
    end
  end

  assign shortWb   = cur.shortWb;
  assign longWb    = cur.longWb;
  assign illegalOp = cur.illegal;
  assign wb_ack_o  = cur.ack;
  assign wb_dat_o  = cur.rdata;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic regByte;
  logic plainReg;
  assign regByte  = go && isReg && byteOp;
  assign plainReg = regByte && !satSel && !carrySel;

  // a wide op issued one cycle earlier answers on the long port in the same
  // cycle, so the long port must carry exactly what the stage held, no more
  property p_byteLatency;
    regByte |=> shortWb.valid && shortWb.dest == $past(dest)
                && longWb.valid == $past(cur.stage.valid);
  endproperty
  a_byteLatency: assert property (p_byteLatency) else $error("byte result late"); // RL11

  property p_wideLatency;
    (go && !byteOp) |=> !shortWb.valid ##1 (longWb.valid && longWb.dest == $past(dest, 2));
  endproperty
  a_wideLatency: assert property (p_wideLatency) else $error("wide result late"); // RL11

  property p_wrap;
    (plainReg && !simd) |=> shortWb.data[7:0] == 8'($past(opB[7:0]) + $past(addend[7:0]))
                            && shortWb.data[63:8] == $past(opB[63:8]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("scalar byte sum wrong"); // RL6

  property p_simdNoCross;
    (plainReg && simd) |=> shortWb.data[15:8] ==
                           8'($past(opB[15:8]) + $past(issue.srcFirst[15:8]));
  endproperty
  a_simdNoCross: assert property (p_simdNoCross) else $error("carry crossed chunk"); // RL3

  property p_satClamp;
    (regByte && satSel && (9'(opB[7:0]) + 9'(addend[7:0]) > 9'h0ff))
      |=> shortWb.data[7:0] == 8'hff;
  endproperty
  a_satClamp: assert property (p_satClamp) else $error("saturation missed"); // RL4

  property p_carryWord;
    (regByte && carrySel && !simd && dest != REG_LAST)
      |=> shortWb.carryValid && shortWb.carryDest == 6'($past(dest) + 6'h01)
          && shortWb.carryData == {56'h0, 7'h00,
             $past(9'(opB[7:0]) + 9'(addend[7:0]) > 9'h0ff)};
  endproperty
  a_carryWord: assert property (p_carryWord) else $error("carry word wrong"); // RL5

  property p_noCarry63;
    (go && carrySel && dest == REG_LAST) |=> !shortWb.carryValid ##1 !longWb.carryValid;
  endproperty
  a_noCarry63: assert property (p_noCarry63) else $error("carry to zero register"); // RL15

  property p_illegal;
    bad |=> illegalOp && cur.illegalSticky && !shortWb.valid ##1 !longWb.valid;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal op executed"); // RL18

  property p_immZeroExt;
    (go && isImm && !simd && sizeCode == SZ_DOUBLE)
      |-> ##2 longWb.data[15:0] == 16'($past(opB[15:0], 2) + {8'h00, $past(imm, 2)});
  endproperty
  a_immZeroExt: assert property (p_immZeroExt) else $error("constant not zero-extended"); // RL8

  property p_narrow;
    (go && cur.narrow && issue.instr[SIZE_HI:SIZE_LO] == SZ_OCTA && !simd)
      |-> ##2 longWb.data[63:32] == $past(opB[63:32], 2);
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow size not mapped"); // RL14

endmodule

// file: inc/ias_pkg.sv
// constants and carrier types for the integer add unit
// assumes a 64-bit register file of 64 entries, register 0 hardwired to zero
package ias_pkg;

  // ----------------------------------------------------------------
  // datapath shape
  // ----------------------------------------------------------------
  localparam int          XLEN         = 64;
  localparam int          NBYTE        = 8;
  localparam logic [5:0]  REG_LAST     = 6'h3f;  // neighbour of this one is the zero register

  // ----------------------------------------------------------------
  // instruction word fields
  // ----------------------------------------------------------------
  localparam int          OPC_HI       = 31;
  localparam int          OPC_LO       = 24;
  localparam int          SIZE_HI      = 23;
  localparam int          SIZE_LO      = 22;
  localparam int          SIMD_BIT     = 21;
  localparam int          RSV_BIT      = 20;
  localparam int          SAT_BIT      = 19;
  localparam int          CARRY_BIT    = 18;
  localparam int          IMM_HI       = 19;
  localparam int          IMM_LO       = 12;
  localparam int          SRC1_HI      = 17;
  localparam int          SRC1_LO      = 12;
  localparam int          SRC2_HI      = 11;
  localparam int          SRC2_LO      = 6;
  localparam int          DST_HI       = 5;
  localparam int          DST_LO       = 0;

  // size codes and their chunk masks (chunk bytes minus one)
  localparam logic [1:0]  SZ_BYTE      = 2'h0;
  localparam logic [1:0]  SZ_DOUBLE    = 2'h1;
  localparam logic [1:0]  SZ_QUAD      = 2'h2;
  localparam logic [1:0]  SZ_OCTA      = 2'h3;
  localparam logic [2:0]  MASK_BYTE    = 3'h0;
  localparam logic [2:0]  MASK_DOUBLE  = 3'h1;
  localparam logic [2:0]  MASK_QUAD    = 3'h3;
  localparam logic [2:0]  MASK_OCTA    = 3'h7;

  // opcode defaults; values are arbitrary and set per implementation
  localparam logic [7:0]  REG_SUM_OPC_DEF = 8'h10;
  localparam logic [7:0]  IMM_SUM_OPC_DEF = 8'h11;

  // ----------------------------------------------------------------
  // wishbone register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADR_CTRL     = 8'h00;
  localparam logic [7:0]  ADR_STATUS   = 8'h04;
  localparam logic [7:0]  ADR_COUNT    = 8'h08;
  localparam int          CTRL_NARROW  = 0;   // 1: size code 11 means four bytes
  localparam int          STAT_ILLEGAL = 0;   // sticky, write one to clear
  localparam logic        CTRL_NARROW_RST = 1'b0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [63:0] srcFirst;   // register named by bits 17-12
    logic [63:0] srcSecond;  // register named by bits 11-6
  } ias_issue_t;

  typedef struct packed {
    logic        valid;
    logic [5:0]  dest;
    logic [63:0] data;
    logic        carryValid;
    logic [5:0]  carryDest;
    logic [63:0] carryData;
  } ias_wb_t;

  typedef struct packed {
    logic        valid;
    logic [5:0]  dest;
    logic        sat;
    logic        carryEn;
    logic [2:0]  mask;
    logic [7:0]  active;
    logic [63:0] passB;
    logic [63:0] s0;
    logic [63:0] s1;
    logic [7:0]  c0;
    logic [7:0]  c1;
  } ias_stage_t;

  typedef struct packed {
    logic        narrow;
    logic        illegalSticky;
    logic [31:0] opCount;
    logic        ack;
    logic [31:0] rdata;
    logic        illegal;
    ias_stage_t  stage;
    ias_wb_t     shortWb;
    ias_wb_t     longWb;
  } ias_state_t;

endpackage

// file: verilog/ias_byte_slice.sv
// one byte of the adder, computed for both carry-in values
// assumes the caller picks the pair once the carry into the byte is known
`timescale 1ns/1ns
module ias_byte_slice
  import ias_pkg::*;
(
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  output logic      [7:0] sum0,
  output logic      [7:0] sum1,
  output logic            cout0,
  output logic            cout1
);

  // carry-select pair: lets the second stage chain bytes with a mux only
  assign {cout0, sum0} = 9'({1'b0, a}) + 9'({1'b0, b});
  assign {cout1, sum1} = 9'({1'b0, a}) + 9'({1'b0, b}) + 9'h001;

endmodule

// file: test/ias_regfile_model.sv
// register file model on the issue side of the add unit, taking its writebacks
// assumes the bench presents one request a cycle, changed just after the clock edge
`timescale 1ns/1ns
module ias_regfile_model
  import ias_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reqValid,
  input  wire logic [31:0] reqInstr,
  input  ias_wb_t          shortWb,
  input  ias_wb_t          longWb,
  output ias_issue_t       issue
);
  logic [63:0] regs [64];

  initial begin
    for (int i = 0; i < 64; i++) begin
      regs[i] = 64'h0;
    end
  end

  // operands are read in the issue cycle, as the decode stage hands them over
  assign issue = {reqValid, reqInstr, regs[reqInstr[SRC1_HI:SRC1_LO]],
                  regs[reqInstr[SRC2_HI:SRC2_LO]]};

  // both ports may land in one cycle; register zero stays zero whatever arrives
  always @(posedge clk_sys) begin
    if (shortWb.valid && shortWb.dest != 6'h00) regs[shortWb.dest] <= shortWb.data;
    if (shortWb.carryValid && shortWb.carryDest != 6'h00) regs[shortWb.carryDest] <= shortWb.carryData;
    if (longWb.valid && longWb.dest != 6'h00) regs[longWb.dest] <= longWb.data;
    if (longWb.carryValid && longWb.carryDest != 6'h00) regs[longWb.carryDest] <= longWb.carryData;
  end

  task automatic put(input logic [5:0] idx, input logic [63:0] val);
    regs[idx] = val;
  endtask
endmodule

// file: test/ias_add_unit_bench.sv
// self-checking bench for the integer add unit
// assumes the register file model beside it and a 25 MHz core clock
`timescale 1ns/1ns
module ias_add_unit_bench;
  import ias_pkg::*;
  typedef struct {int due; logic [5:0] dest; logic [63:0] data; logic cv; logic [63:0] cd;} ias_exp_t;
  logic        clk_sys, rst, reqValid, wbCyc, wbStb, wbWe, wbAck, illegalOp, narrowMode;
  logic [31:0] reqInstr, wbDatW, wbDatR, rd;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  ias_issue_t  issue;
  ias_wb_t     shortWb, longWb;
  int          n_fail, samples_checked, cyc, nOps;
  logic [63:0] shadow [64];
  ias_exp_t    expS[$], expL[$];
  int          expI[$];

  ias_add_unit ias_add_unit_i (.clk_sys(clk_sys), .rst(rst), .issue(issue), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .shortWb(shortWb), .longWb(longWb), .illegalOp(illegalOp));
  ias_regfile_model ias_regfile_model_i (.clk_sys(clk_sys), .reqValid(reqValid),
    .reqInstr(reqInstr), .shortWb(shortWb), .longWb(longWb), .issue(issue));

  // --------------------------------------------------------------
  // checking helpers
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // reference sum: chunk by chunk, upper bytes of a scalar op pass from the second source
  function automatic ias_exp_t model_op(input logic [31:0] ins);
    ias_exp_t    e;
    logic        isImm, sat;
    int          nb, w, n;
    logic [64:0] m, s, ca, cb;
    isImm = ins[OPC_HI:OPC_LO] == IMM_SUM_OPC_DEF;
    sat = !isImm && ins[SAT_BIT];
    nb = (narrowMode && ins[SIZE_HI:SIZE_LO] == SZ_OCTA) ? 4 : 1 << ins[SIZE_HI:SIZE_LO];
    w = nb * 8;
    n = ins[SIMD_BIT] ? NBYTE / nb : 1;
    m = (65'h1 << w) - 65'h1;
    e.data = shadow[ins[SRC2_HI:SRC2_LO]];
    e.cd = 64'h0;
    for (int k = 0; k < n; k++) begin
      ca = isImm ? 65'(ins[IMM_HI:IMM_LO]) : (65'(shadow[ins[SRC1_HI:SRC1_LO]]) >> (k * w)) & m;
      cb = (65'(e.data) >> (k * w)) & m;
      s = ca + cb;
      if (sat && s[w]) s = m;
      e.data = (e.data & ~64'(m << (k * w))) | 64'((s & m) << (k * w));
      e.cd = e.cd | 64'(65'(s[w]) << (k * w));
    end
    e.dest = ins[DST_HI:DST_LO];
    e.cv = !isImm && ins[CARRY_BIT] && e.dest != REG_LAST;
    e.due = cyc + (nb == 1 ? 2 : 3);
    return e;
  endfunction

  // compare one writeback port against the oldest expectation due this cycle
  task automatic check_port(input ias_wb_t p, ref ias_exp_t q[$]);
    ias_exp_t e;
    if (q.size() > 0 && q[0].due == cyc) begin
      e = q.pop_front();
      check("valid", 64'(p.valid), 64'h1);
      check("dest", 64'(p.dest), 64'(e.dest));
      check("data", p.data, e.data);
      check("carryValid", 64'(p.carryValid), 64'(e.cv));
      if (e.cv) begin
        check("carryDest", 64'(p.carryDest), 64'(e.dest + 6'h1));
        check("carryData", p.carryData, e.cd);
      end
    end else begin
      check("stray valid", 64'(p.valid), 64'h0);
    end
  endtask

  // outputs settle by the falling edge, so the scoreboard looks there
  always @(negedge clk_sys) begin
    if (!rst) begin
      check_port(shortWb, expS);
      check_port(longWb, expL);
      if (expI.size() > 0 && expI[0] == cyc) begin
        void'(expI.pop_front());
        check("illegal", 64'(illegalOp), 64'h1);
      end else check("illegal idle", 64'(illegalOp), 64'h0);
    end
  end

  // --------------------------------------------------------------
  // drivers
  // --------------------------------------------------------------
  function automatic logic [31:0] rop(input logic [1:0] sz, input logic [3:0] fl,
                                      input int a, input int b, input int d);
    return {REG_SUM_OPC_DEF, sz, fl, 6'(a), 6'(b), 6'(d)}; // flags: simd, reserved zero, saturate, carry
  endfunction

  function automatic logic [31:0] iop(input logic [1:0] sz, input logic simd,
                                      input int b, input int d);
    return {IMM_SUM_OPC_DEF, sz, simd, 1'b0, 8'h87, 6'(b), 6'(d)};
  endfunction

  task automatic put(input int idx, input logic [63:0] val);
    shadow[idx] = val;
    ias_regfile_model_i.put(6'(idx), val);
  endtask

  task automatic issue_op(input logic [31:0] ins);
    ias_exp_t e;
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqInstr <= ins;
    if (ins[OPC_HI:OPC_LO] == REG_SUM_OPC_DEF && ins[SAT_BIT] && ins[CARRY_BIT]) begin
      expI.push_back(cyc + 2);
    end else if (ins[OPC_HI:OPC_LO] inside {REG_SUM_OPC_DEF, IMM_SUM_OPC_DEF}) begin
      nOps++;
      e = model_op(ins);
      if (e.due == cyc + 2) expS.push_back(e);
      else expL.push_back(e);
    end
  endtask

  task automatic drain();
    int n;
    n = 0;
    @(posedge clk_sys);
    reqValid <= 1'b0;
    while (expS.size() + expL.size() + expI.size() > 0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    check("drained", 64'(expS.size() + expL.size() + expI.size()), 64'h0);
  endtask

  // one classic cycle; the request stands until ack is sampled at a rising edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hf;
    wbDatW <= dat;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    check("ack", 64'(n < 50), 64'h1);
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_examples();
    put(1, 64'hf8);
    put(2, 64'h0f);
    put(9, 64'h000000f800000001);
    put(10, 64'h00f80f00f045ff82);
    issue_op(rop(SZ_BYTE, 4'b0000, 1, 2, 3));
    issue_op(rop(SZ_BYTE, 4'b0010, 1, 2, 5));
    issue_op(rop(SZ_BYTE, 4'b0001, 1, 2, 7));
    issue_op(rop(SZ_BYTE, 4'b1001, 9, 2, 24));
    issue_op(rop(SZ_OCTA, 4'b0001, 1, 2, 63));
    for (int i = 0; i < 8; i++) issue_op(iop(i[2:1], i[0], 10, 6'(13 + i)));
    drain();
    check("add.b wrap", ias_regfile_model_i.regs[3], 64'h07);
    check("add.b sat", ias_regfile_model_i.regs[5], 64'hff);
    check("add.b carry", ias_regfile_model_i.regs[8], 64'h01);
    check("addi.b", ias_regfile_model_i.regs[13], 64'h00f80f00f045ff09);
    check("saddi.b", ias_regfile_model_i.regs[14], 64'h877f968777cc8609);
    check("addi.d", ias_regfile_model_i.regs[15], 64'h00f80f00f0450009);
    check("saddi.d", ias_regfile_model_i.regs[16], 64'h017f0f87f0cc0009);
  endtask

  // every size, partition and option back to back, with a foreign opcode in between
  task automatic t_sizes();
    int d;
    d = 32;
    put(11, 64'hfedcba9876543210);
    put(12, 64'h8123456789abcdef);
    for (int sz = 0; sz < 4; sz++) begin
      for (int f = 0; f < 8; f++) begin
        if (f[1:0] != 2'h3) begin
          issue_op(rop(sz[1:0], {f[2], 1'b0, f[1:0]}, 11, 12, 6'(d)));
          d++;
        end
      end
      if (sz == 1) issue_op({8'h55, 24'h0c32c1});
    end
    drain();
    wb_xfer(1'b0, ADR_COUNT, 32'h0);
    check("count", 64'(rd), 64'(nOps));
  endtask

  task automatic t_regs_and_illegal();
    wb_xfer(1'b0, 8'h0c, 32'h0);
    check("unmapped", 64'(rd), 64'h0);
    wb_xfer(1'b1, ADR_CTRL, 32'h1);
    wb_xfer(1'b0, ADR_CTRL, 32'h0);
    check("ctrl", 64'(rd), 64'h1);
    narrowMode = 1'b1;
    issue_op(rop(SZ_OCTA, 4'b0000, 11, 12, 60));
    issue_op(rop(SZ_OCTA, 4'b1001, 11, 12, 61));
    issue_op(rop(SZ_BYTE, 4'b0011, 11, 12, 40));
    drain();
    narrowMode = 1'b0;
    wb_xfer(1'b1, ADR_CTRL, 32'h0);
    wb_xfer(1'b0, ADR_STATUS, 32'h0);
    check("status set", 64'(rd), 64'h1);
    wb_xfer(1'b1, ADR_STATUS, 32'h1);
    wb_xfer(1'b0, ADR_STATUS, 32'h0);
    check("status clear", 64'(rd), 64'h0);
  endtask

  // --------------------------------------------------------------
  // clock, cycle count with hang guard, main sequence
  // --------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    {rst, reqValid, wbCyc, wbStb, wbWe, narrowMode} = 6'b100000;
    {reqInstr, wbDatW, wbAdr, wbSel} = '0;
    {n_fail, samples_checked, cyc, nOps} = '0;
    for (int i = 0; i < 64; i++) shadow[i] = 64'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    wb_xfer(1'b0, ADR_STATUS, 32'h0);
    check("status reset", 64'(rd), 64'h0);
    t_examples();
    t_sizes();
    t_regs_and_illegal();
    print_verdict();
  end
endmodule
